// >>> tb.sv
// Self-checking bench for the voice codec serial port
`timescale 1ns/100ps
module tb;
   import vcsp_pkg::*;
   // Bus, pins and bench state
   logic aclk = 1'b0, aresetn = 1'b0, awready, wready, bvalid, arready, rvalid;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [ADDR_W-1:0] awaddr = 4'h0, araddr = 4'h0;
   logic [DATA_W-1:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp;
   logic [2:0] awprot = 3'h0, arprot = 3'h0;
   logic [3:0] wstrb = 4'hf;
   logic master_clock, rx_bit_clock, rx_frame_sync, tx_frame_sync, rx_serial_data;
   logic tx_bit_clock, tx_slot_strobe_n_in, tx_slot_strobe_n_out, tx_slot_strobe_n_oe;
   logic tx_serial_data, tx_serial_active, earphone_amp_en, powered_down;
   logic coding_select = 1'b0, mic_mute_n = 1'b1, earphone_mute_n = 1'b1;
   logic power_down_n = 1'b1, fixed_mode = 1'b1, strobe_seen = 1'b0;
   logic [31:0] rnd = 32'h5e7d;
   int err_total = 0, cmp_count = 0, cyc = 0, cnt = 0;

   vcsp_serial_port #(.FRAME_CLKS(16)) vcsp_serial_port_i (.*);
   vcsp_dsp_model vcsp_dsp_model_i (.*);

   // Shared pin: pull-up in fixed mode, host bit clock in variable mode
   assign tx_slot_strobe_n_in = tx_slot_strobe_n_oe ? tx_slot_strobe_n_out
                                                    : (fixed_mode | tx_bit_clock);
   always #4 aclk = ~aclk;

   // Cycle ceiling and strobe watch
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (tx_slot_strobe_n_oe === 1'b1) strobe_seen <= 1'b1;
      if (cyc == 30000) begin
         err_total++;
         give_verdict();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Write: both channels offered together, each dropped once taken
   task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic give_verdict();
      if (err_total == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      logic [31:0] d;
      logic [15:0] txw, rxw, got, etx, erx;
      logic [1:0] r;
      int n;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      // Unmapped read and a write to a read-only place
      axr(4'hc, d, r);
      chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk("unmapped data", 32'h0, d);
      axw(ADDR_STATUS, 32'hffff_ffff, r);
      chk("ro write resp", {30'h0, RESP_OKAY}, {30'h0, r});
      // Both syncs low past five frames: both channels in standby
      vcsp_dsp_model_i.idle(1'b0, 1'b0, 90);
      axr(ADDR_STATUS, d, r);
      chk("status idle", 32'h7, d);
      // Fixed then variable rate, linear and companded, muted and not
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         txw = rnd[15:0];
         rxw = rnd[31:16];
         axw(ADDR_TX_WORD, {16'h0, txw}, r);
         fixed_mode <= (i < 4);
         coding_select <= i[0];
         mic_mute_n <= !i[1];
         earphone_mute_n <= rnd[7];
         vcsp_dsp_model_i.idle(1'b0, 1'b0, 6);
         n = i[0] ? 8 : 16;
         strobe_seen = 1'b0;
         vcsp_dsp_model_i.frame(rxw, n, got);
         repeat (8) @(posedge aclk);
         cnt++;
         etx = i[0] ? {8'h0, (i[1] ? ZERO_MU_LAW : txw[7:0])}
                    : (i[1] ? ZERO_LINEAR : {txw[15:3], 3'b000});
         erx = i[0] ? {8'h0, rxw[7:0]} : rxw;
         chk("tx word", {16'h0, etx}, {16'h0, got});
         chk("strobe", {31'h0, fixed_mode}, {31'h0, strobe_seen});
         chk("amp enable", {31'h0, rnd[7]}, {31'h0, earphone_amp_en});
         axr(ADDR_RX_WORD, d, r);
         chk("rx word", {cnt[15:0], erx}, d);
         axr(ADDR_STATUS, d, r);
         chk("status", {25'h0, rnd[7], i[0], 4'b0000, fixed_mode}, d);
      end
      // Receive sync stuck high: test mode, transmit side alone in standby
      vcsp_dsp_model_i.idle(1'b1, 1'b0, 90);
      axr(ADDR_STATUS, d, r);
      chk("status stuck", 32'h2c, d);
      // Powered down: no slot is shifted and the word count stands still
      power_down_n <= 1'b0;
      fixed_mode <= 1'b1;
      vcsp_dsp_model_i.idle(1'b0, 1'b0, 6);
      strobe_seen = 1'b0;
      vcsp_dsp_model_i.frame(16'ha5c3, 16, got);
      axr(ADDR_RX_WORD, d, r);
      chk("pd count", {16'h0, cnt[15:0]}, {16'h0, d[31:16]});
      chk("pd strobe", 32'h0, {31'h0, strobe_seen});
      chk("pd pin", 32'h1, {31'h0, powered_down});
      give_verdict();
   end
endmodule // tb

// >>> vcsp_dsp_model.sv
// Host serial port model: master clock, bit clocks, frame syncs, data
`timescale 1ns/100ps
module vcsp_dsp_model (
   // Mode and observed transmit data
   input wire logic fixed_mode,
   input wire logic tx_serial_data,
   // Clocks, syncs and receive data
   output logic master_clock,
   output logic rx_bit_clock,
   output logic tx_bit_clock,
   output logic rx_frame_sync,
   output logic tx_frame_sync,
   output logic rx_serial_data
);
   logic run = 1'b0;

   // Master clock runs free, frames are counted on it
   initial begin
      master_clock = 1'b0;
      rx_frame_sync = 1'b0;
      tx_frame_sync = 1'b0;
      rx_serial_data = 1'b0;
   end
   always #40 master_clock = ~master_clock;

   // Bit clocks stand still low between slots (receive clock tied high in fixed mode); gated in the low phase to avoid runts
   assign tx_bit_clock = run & master_clock;
   assign rx_bit_clock = fixed_mode | tx_bit_clock;

   // Hold both syncs at given levels for n master clocks
   task automatic idle(input logic rl, input logic tl, input int n);
      rx_frame_sync = rl;
      tx_frame_sync = tl;
      repeat (n) @(posedge master_clock);
   endtask

   // One slot: send w MSB first, capture n transmit bits a period late
   task automatic frame(input logic [15:0] w, input int n, output logic [15:0] got);
      got = 16'h0;
      @(negedge master_clock);
      run = 1'b1;
      // Transmit sync rises half a period before the first rising edge
      tx_frame_sync = 1'b1;
      for (int k = 0; k <= n + 1; k++) begin
         @(posedge master_clock);
         if (k >= 1 && k <= n) got[n - k] = tx_serial_data;
         #1;
         rx_frame_sync = (k == 0) || (!fixed_mode && k < n);
         // Released data line toggles so a stale bit is never read
         rx_serial_data = (k < n) ? w[n - 1 - k] : ~rx_serial_data;
         // Sync falls mid-period so no rising edge sees it change
         if (k == 0) begin
            @(negedge master_clock);
            tx_frame_sync = 1'b0;
         end
      end
      @(negedge master_clock);
      run = 1'b0;
   endtask
endmodule // vcsp_dsp_model

// >>> vcsp_pin_sync.sv
// Two-stage pin synchroniser with edge pulses
`timescale 1ns/100ps
module vcsp_pin_sync (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Asynchronous pin
   input wire logic pin,
   // Synchronised level and one-cycle edge pulses
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_ff;
   logic sync_ff;
   logic last_ff;

   // First stage feeds only the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
      end else begin
         meta_ff <= pin;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   assign level = sync_ff;
   assign rise = sync_ff & ~last_ff;
   assign fall = ~sync_ff & last_ff;
endmodule // vcsp_pin_sync

// >>> vcsp_pkg.sv
// Shared constants for the voice codec serial port block
package vcsp_pkg;

   // Bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_TX_WORD = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_RX_WORD = 4'h8;

   // Status register field positions
   localparam int ST_FIXED_MODE = 0;
   localparam int ST_RX_STANDBY = 1;
   localparam int ST_TX_STANDBY = 2;
   localparam int ST_TEST_MODE = 3;
   localparam int ST_POWERED_DOWN = 4;
   localparam int ST_COMPANDED = 5;
   localparam int ST_EAR_ENABLED = 6;

   // Receive word register fields
   localparam int RXW_COUNT_LSB = 16;

   // Reset values
   localparam logic [15:0] TX_WORD_RST = 16'h0000;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Serial word geometry
   localparam int WORD_COMP_BITS = 8;
   localparam int WORD_LIN_BITS = 16;
   localparam int LIN_DATA_BITS = 13;
   localparam int BIT_CNT_W = 5;

   // Zero codes for a muted microphone
   localparam logic [7:0] ZERO_MU_LAW = 8'hff;
   localparam logic [7:0] ZERO_A_LAW = 8'hd5;
   localparam logic [15:0] ZERO_LINEAR = 16'h0000;

   // Frame supervision
   localparam int IDLE_FRAMES = 5;
   localparam int FRAME_CLKS_DEF = 256;
   localparam int MODE_DETECT_CLKS = 4;

   // Pin index map into the synchroniser bank
   localparam int NUM_PINS = 10;
   localparam int PIN_MCLK = 0;
   localparam int PIN_RXCLK = 1;
   localparam int PIN_TXCLK = 2;
   localparam int PIN_RXFS = 3;
   localparam int PIN_TXFS = 4;
   localparam int PIN_RXD = 5;
   localparam int PIN_CODING = 6;
   localparam int PIN_MIC_MUTE_N = 7;
   localparam int PIN_EARPHONE_MUTE_N = 8;
   localparam int PIN_PWR = 9;

   // Slot shifter state
   typedef enum logic [0:0] {
      SLOT_IDLE = 1'b0,
      SLOT_SHIFT = 1'b1
   } vcsp_slot_t;

endpackage

// >>> vcsp_serial_port.sv
// Voice codec serial port: framing, shifting, control pins, register slave
`timescale 1ns/100ps

// Behaviour
// - Receive bits are sampled on falling edges of the master clock (fixed) or receive bit clock (variable).
// - Transmit bits change on rising edges of the master clock (fixed) or transmit bit clock (variable).
// - The receive channel goes to standby after its frame sync stays low five frames or more.
// - The transmit channel goes to standby after its frame sync stays low five frames or more.
// - Either frame sync held high five frames or more puts the device into test mode.
// - The transmit frame sync frames the transmit channel independently of the receive side.
// - Coding select low means linear coding, high means companded coding (mu-law or A-law variant).
// - While the microphone mute is low, every transmit slot carries the zero code.
// - While the earphone mute is low, the earphone amplifier is disabled.
// - While the power-down input is low, the device is powered down.
// - In fixed-rate mode the device pulls the shared strobe pin low during its transmit slot.
// - Receive bit clock pin tied high selects fixed-rate mode, otherwise variable-rate mode.
// - Serial words are 8 bits companded, 16 bits linear: 13 data bits then 3 gain or zero bits.
module vcsp_serial_port #(
   parameter int FRAME_CLKS = vcsp_pkg::FRAME_CLKS_DEF,
   parameter bit COMPAND_A_LAW = 1'b0
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [vcsp_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [vcsp_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [vcsp_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [vcsp_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // Serial link clocks and frame syncs
   input wire logic master_clock,
   input wire logic rx_bit_clock,
   input wire logic rx_frame_sync,
   input wire logic tx_frame_sync,
   // Shared strobe / transmit bit clock pin
   input wire logic tx_slot_strobe_n_in,
   output logic tx_slot_strobe_n_out,
   output logic tx_slot_strobe_n_oe,
   // Serial data
   input wire logic rx_serial_data,
   output logic tx_serial_data,
   output logic tx_serial_active,
   // Control pins
   input wire logic coding_select,
   input wire logic mic_mute_n,
   input wire logic earphone_mute_n,
   input wire logic power_down_n,
   // Analog-side enables
   output logic earphone_amp_en,
   output logic powered_down
);
   import vcsp_pkg::*;
   localparam int IDLE_LIMIT = IDLE_FRAMES * FRAME_CLKS;
   localparam int IDLE_W = $clog2(IDLE_LIMIT + 1);
   localparam logic [IDLE_W-1:0] IDLE_MAX = IDLE_W'(IDLE_LIMIT);
   localparam logic [2:0] MODE_MAX = 3'(MODE_DETECT_CLKS);

   // Frame must hold a linear word and fit the idle counters
   if (FRAME_CLKS < WORD_LIN_BITS || FRAME_CLKS > 65536) begin : g_bad_frame
      $error("FRAME_CLKS out of range");
   end

   logic [NUM_PINS-1:0] pin_raw;
   logic [NUM_PINS-1:0] pin_lvl;
   logic [NUM_PINS-1:0] pin_rise;
   logic [NUM_PINS-1:0] pin_fall;

   assign pin_raw[PIN_MCLK] = master_clock;
   assign pin_raw[PIN_RXCLK] = rx_bit_clock;
   assign pin_raw[PIN_TXCLK] = tx_slot_strobe_n_in;
   assign pin_raw[PIN_RXFS] = rx_frame_sync;
   assign pin_raw[PIN_TXFS] = tx_frame_sync;
   assign pin_raw[PIN_RXD] = rx_serial_data;
   assign pin_raw[PIN_CODING] = coding_select;
   assign pin_raw[PIN_MIC_MUTE_N] = mic_mute_n;
   assign pin_raw[PIN_EARPHONE_MUTE_N] = earphone_mute_n;
   assign pin_raw[PIN_PWR] = power_down_n;

   // Every pin crosses into aclk through two flops
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_sync
      vcsp_pin_sync u_sync (
         .aclk(aclk),
         .aresetn(aresetn),
         .pin(pin_raw[p]),
         .level(pin_lvl[p]),
         .rise(pin_rise[p]),
         .fall(pin_fall[p])
      );
   end

   // Mode strap: rx clock high across several master clocks means tied high
   logic fixed_mode_ff;
   logic [2:0] mode_cnt_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fixed_mode_ff <= 1'b0;
         mode_cnt_ff <= 3'h0;
      end else if (pin_fall[PIN_RXCLK] || !pin_lvl[PIN_RXCLK]) begin
         fixed_mode_ff <= 1'b0;
         mode_cnt_ff <= 3'h0;
      end else if (pin_rise[PIN_MCLK] && mode_cnt_ff != MODE_MAX) begin
         mode_cnt_ff <= mode_cnt_ff + 3'h1;
      end else if (mode_cnt_ff == MODE_MAX) begin
         fixed_mode_ff <= 1'b1;
      end
   end

   // Power and coding follow their pins
   logic companded;
   logic powered_down_ff;
   assign companded = pin_lvl[PIN_CODING];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         powered_down_ff <= 1'b0;
      end else begin
         powered_down_ff <= ~pin_lvl[PIN_PWR];
      end
   end

   // Idle frame watch per channel; frames are counted in master clocks
   // because the data clocks may stop while a channel is idle
   logic [1:0] fs_lvl;
   logic [IDLE_W-1:0] low_cnt_ff [2];
   logic [IDLE_W-1:0] high_cnt_ff [2];
   logic [1:0] standby_ff;
   logic [1:0] held_high_ff;
   assign fs_lvl = {pin_lvl[PIN_TXFS], pin_lvl[PIN_RXFS]};

   for (genvar c = 0; c < 2; c++) begin : g_watch
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            low_cnt_ff[c] <= '0;
            high_cnt_ff[c] <= '0;
            standby_ff[c] <= 1'b0;
            held_high_ff[c] <= 1'b0;
         end else begin
            if (fs_lvl[c]) begin
               low_cnt_ff[c] <= '0;
               standby_ff[c] <= 1'b0;
            end else if (low_cnt_ff[c] == IDLE_MAX) begin
               standby_ff[c] <= 1'b1;
            end else if (pin_rise[PIN_MCLK]) begin
               low_cnt_ff[c] <= low_cnt_ff[c] + 1'b1;
            end
            if (!fs_lvl[c]) begin
               high_cnt_ff[c] <= '0;
               held_high_ff[c] <= 1'b0;
            end else if (high_cnt_ff[c] == IDLE_MAX) begin
               held_high_ff[c] <= 1'b1;
            end else if (pin_rise[PIN_MCLK]) begin
               high_cnt_ff[c] <= high_cnt_ff[c] + 1'b1;
            end
         end
      end
   end

   logic test_mode;
   logic rx_active;
   logic tx_active;
   assign test_mode = |held_high_ff;
   assign rx_active = ~powered_down_ff & ~standby_ff[0] & ~test_mode;
   assign tx_active = ~powered_down_ff & ~standby_ff[1] & ~test_mode;

   // Word length by coding
   logic [BIT_CNT_W-1:0] word_len;
   assign word_len = companded ? BIT_CNT_W'(WORD_COMP_BITS) : BIT_CNT_W'(WORD_LIN_BITS);

   // Bit clock edges chosen by mode
   logic rx_edge;
   logic tx_edge;
   assign rx_edge = fixed_mode_ff ? pin_fall[PIN_MCLK] : pin_fall[PIN_RXCLK];
   assign tx_edge = fixed_mode_ff ? pin_rise[PIN_MCLK] : pin_rise[PIN_TXCLK];

   // Receive shifter
   vcsp_slot_t rx_state_ff;
   logic [BIT_CNT_W-1:0] rx_cnt_ff;
   logic [15:0] rx_sh_ff;
   logic [15:0] rx_word_ff;
   logic [15:0] rx_count_ff;
   logic [15:0] nxt_rx_sh;
   logic [BIT_CNT_W-1:0] nxt_rx_cnt;
   assign nxt_rx_sh = {rx_sh_ff[14:0], pin_lvl[PIN_RXD]};
   assign nxt_rx_cnt = rx_cnt_ff + 1'b1;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_state_ff <= SLOT_IDLE;
         rx_cnt_ff <= '0;
         rx_sh_ff <= 16'h0000;
         rx_word_ff <= 16'h0000;
         rx_count_ff <= 16'h0000;
      end else if (!rx_active) begin
         rx_state_ff <= SLOT_IDLE;
      end else if (rx_edge) begin
         case (rx_state_ff)
            SLOT_IDLE: begin
               if (fs_lvl[0]) begin
                  rx_sh_ff <= nxt_rx_sh;
                  rx_cnt_ff <= BIT_CNT_W'(1);
                  rx_state_ff <= SLOT_SHIFT;
               end
            end
            SLOT_SHIFT: begin
               if (!fixed_mode_ff && !fs_lvl[0]) begin
                  rx_state_ff <= SLOT_IDLE;
               end else begin
                  rx_sh_ff <= nxt_rx_sh;
                  rx_cnt_ff <= nxt_rx_cnt;
                  if (nxt_rx_cnt == word_len) begin
                     rx_word_ff <= companded ? {8'h00, nxt_rx_sh[7:0]} : nxt_rx_sh;
                     rx_count_ff <= rx_count_ff + 16'h0001;
                     rx_state_ff <= SLOT_IDLE;
                  end
               end
            end
            default: rx_state_ff <= SLOT_IDLE;
         endcase
      end
   end

   // Transmit word: data bits then zero padding, or the zero code when muted
   logic [15:0] tx_word_ff;
   logic [15:0] tx_load;
   logic [7:0] comp_zero;
   assign comp_zero = COMPAND_A_LAW ? ZERO_A_LAW : ZERO_MU_LAW;
   always_comb begin
      if (!pin_lvl[PIN_MIC_MUTE_N]) begin
         tx_load = companded ? {comp_zero, 8'h00} : ZERO_LINEAR;
      end else if (companded) begin
         tx_load = {tx_word_ff[7:0], 8'h00};
      end else begin
         tx_load = {tx_word_ff[15:16-LIN_DATA_BITS], 3'b000};
      end
   end

   // Transmit shifter
   vcsp_slot_t tx_state_ff;
   logic [BIT_CNT_W-1:0] tx_cnt_ff;
   logic [15:0] tx_sh_ff;
   logic tx_data_ff;
   logic tx_act_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_state_ff <= SLOT_IDLE;
         tx_cnt_ff <= '0;
         tx_sh_ff <= 16'h0000;
         tx_data_ff <= 1'b0;
         tx_act_ff <= 1'b0;
      end else if (!tx_active) begin
         tx_state_ff <= SLOT_IDLE;
         tx_act_ff <= 1'b0;
         tx_data_ff <= 1'b0;
      end else if (tx_edge) begin
         case (tx_state_ff)
            SLOT_IDLE: begin
               if (fs_lvl[1]) begin
                  tx_data_ff <= tx_load[15];
                  tx_sh_ff <= {tx_load[14:0], 1'b0};
                  tx_cnt_ff <= BIT_CNT_W'(1);
                  tx_act_ff <= 1'b1;
                  tx_state_ff <= SLOT_SHIFT;
               end
            end
            SLOT_SHIFT: begin
               if (tx_cnt_ff == word_len) begin
                  tx_data_ff <= 1'b0;
                  tx_act_ff <= 1'b0;
                  tx_state_ff <= SLOT_IDLE;
               end else begin
                  tx_data_ff <= tx_sh_ff[15];
                  tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
                  tx_cnt_ff <= tx_cnt_ff + 1'b1;
               end
            end
            default: tx_state_ff <= SLOT_IDLE;
         endcase
      end
   end

   // Open-drain strobe only in fixed-rate mode; in variable mode the pin is an input
   logic strobe_oe_ff;
   logic ear_en_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strobe_oe_ff <= 1'b0;
         ear_en_ff <= 1'b0;
      end else begin
         strobe_oe_ff <= fixed_mode_ff & tx_act_ff;
         ear_en_ff <= pin_lvl[PIN_EARPHONE_MUTE_N] & rx_active;
      end
   end

   // AXI4-Lite write path: address and data taken in either order
   logic aw_got_ff;
   logic w_got_ff;
   logic [ADDR_W-1:0] waddr_ff;
   logic [DATA_W-1:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         waddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         tx_word_ff <= TX_WORD_RST;
      end else begin
         if (awvalid && awready) begin
            aw_got_ff <= 1'b1;
            waddr_ff <= awaddr;
         end
         if (wvalid && wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
         end
         if (aw_got_ff && w_got_ff && !bvalid_ff) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            if (waddr_ff[ADDR_W-1:2] == ADDR_TX_WORD[ADDR_W-1:2]) begin
               bresp_ff <= RESP_OKAY;
               if (wstrb_ff[0]) tx_word_ff[7:0] <= wdata_ff[7:0];
               if (wstrb_ff[1]) tx_word_ff[15:8] <= wdata_ff[15:8];
            end else if (waddr_ff[ADDR_W-1:2] == ADDR_STATUS[ADDR_W-1:2] ||
                         waddr_ff[ADDR_W-1:2] == ADDR_RX_WORD[ADDR_W-1:2]) begin
               bresp_ff <= RESP_OKAY; // Read-only, write ignored
            end else begin
               bresp_ff <= RESP_SLVERR;
            end
         end else if (bvalid_ff && bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end
   assign awready = ~aw_got_ff & ~bvalid_ff;
   assign wready = ~w_got_ff & ~bvalid_ff;

   // AXI4-Lite read path: one cycle from address to data
   logic rvalid_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [DATA_W-1:0] status_word;
   always_comb begin
      status_word = '0;
      status_word[ST_FIXED_MODE] = fixed_mode_ff;
      status_word[ST_RX_STANDBY] = standby_ff[0];
      status_word[ST_TX_STANDBY] = standby_ff[1];
      status_word[ST_TEST_MODE] = test_mode;
      status_word[ST_POWERED_DOWN] = powered_down_ff;
      status_word[ST_COMPANDED] = companded;
      status_word[ST_EAR_ENABLED] = ear_en_ff;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= RESP_OKAY;
         case (araddr[ADDR_W-1:2])
            ADDR_STATUS[ADDR_W-1:2]: rdata_ff <= status_word;
            ADDR_TX_WORD[ADDR_W-1:2]: rdata_ff <= {16'h0000, tx_word_ff};
            ADDR_RX_WORD[ADDR_W-1:2]: rdata_ff <= {rx_count_ff, rx_word_ff};
            default: begin
               rdata_ff <= '0;
               rresp_ff <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid_ff && rready) begin
         rvalid_ff <= 1'b0;
      end
   end
   assign arready = ~rvalid_ff;

   // Outputs
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   assign tx_slot_strobe_n_out = 1'b0; // Open drain only ever pulls low
   assign tx_slot_strobe_n_oe = strobe_oe_ff;
   assign tx_serial_data = tx_data_ff;
   assign tx_serial_active = tx_act_ff;
   assign earphone_amp_en = ear_en_ff;
   assign powered_down = powered_down_ff;
endmodule // vcsp_serial_port

// >>> vcsp_serial_port_properties.sv
// Property checker bound to the serial port top
`timescale 1ns/100ps
module vcsp_serial_port_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus write side
   input wire logic awready,
   input wire logic bvalid,
   // Strobe and transmit pins
   input wire logic tx_slot_strobe_n_out,
   input wire logic tx_slot_strobe_n_oe,
   input wire logic tx_serial_data,
   input wire logic tx_serial_active,
   // Control pins and analog-side enables
   input wire logic coding_select,
   input wire logic mic_mute_n,
   input wire logic earphone_mute_n,
   input wire logic power_down_n,
   input wire logic earphone_amp_en,
   input wire logic powered_down
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Open drain: the pin may only ever be pulled low
   a_strobe_open_drain: assert property (tx_slot_strobe_n_out == 1'b0)
      else $error("strobe pin driven high");
   a_strobe_in_slot: assert property ($rose(tx_slot_strobe_n_oe) |-> tx_serial_active)
      else $error("strobe pulled outside a transmit slot");
   // Synchroniser plus register takes three cycles, eight leaves margin
   a_pd_enter: assert property (!power_down_n [*8] |-> powered_down)
      else $error("power down not entered");
   a_pd_leave: assert property (power_down_n [*8] |-> !powered_down)
      else $error("power down not left");
   a_no_tx_pd: assert property ($rose(tx_serial_active) |-> !$past(powered_down))
      else $error("slot started while powered down");
   a_ear_mute_off: assert property (!earphone_mute_n [*6] |-> !earphone_amp_en)
      else $error("earphone amp on while muted");
   a_ear_pd_off: assert property (powered_down [*2] |-> !earphone_amp_en)
      else $error("earphone amp on while powered down");
   // Zero code MSB is 0 for linear and 1 for both companding laws
   a_mute_code: assert property ((!mic_mute_n && $stable(coding_select)) [*8] ##1
      $rose(tx_serial_active) |-> tx_serial_data == coding_select)
      else $error("muted slot does not start with zero code");
   a_aw_blocked: assert property (bvalid |-> !awready)
      else $error("write address accepted during response");
endmodule // vcsp_serial_port_checker

bind vcsp_serial_port vcsp_serial_port_checker vcsp_serial_port_checker_i (.*);
